// ===== verilog/ssrp_pkg.sv
// Constants, encodings and helpers shared by the sensor serial register port.
package ssrp_pkg;

	// ------------------------------------------------------------
	// Register space
	// ------------------------------------------------------------
	localparam int BANK_BITS = 3;
	localparam int ADDR_BITS = 8;
	localparam int INDEX_BITS = 11;
	localparam int REG_COUNT = 1280;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Bank select codes; bit 7 marks a read.
	localparam logic [7:0] WRITE_CODE_FIRST = 8'h02;
	localparam logic [7:0] WRITE_CODE_LAST = 8'h06;
	localparam logic [7:0] READ_CODE_FIRST = 8'h82;
	localparam logic [7:0] READ_CODE_LAST = 8'h86;
	localparam int READ_FLAG_BIT = 7;
	localparam logic [2:0] BANK_BASE = 3'h2;

	// Immediate-update region: addresses below this limit in bank 0.
	localparam logic [2:0] IMM_BANK = 3'h0;
	localparam logic [7:0] IMM_ADDR_LIMIT = 8'h10;

	// Serial bit counter.
	localparam logic [2:0] LAST_BIT = 3'h7;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		IF_NONE = 2'h0,
		IF_FOUR_WIRE = 2'h1,
		IF_TWO_WIRE = 2'h2
	} ssrp_iface_t;

	// Gray codes along idle, code, address, data.
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CODE = 3'h1,
		ST_ADDR = 3'h3,
		ST_DATA = 3'h2,
		ST_IGNORE = 3'h6
	} ssrp_state_t;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [INDEX_BITS-1:0] reg_index(input logic [2:0] bank,
		input logic [7:0] addr);
		reg_index = {bank, addr};
	endfunction

	function automatic logic is_immediate(input logic [INDEX_BITS-1:0] index);
		is_immediate = (index[10:8] == IMM_BANK) && (index[7:0] < IMM_ADDR_LIMIT);
	endfunction

endpackage

// ===== verilog/ssrp_serial_port.sv
// Four-wire serial register port with two-wire detection and frame-timed update.
//
// Operation
// - First transaction fixes interface until reset.
// - Every four-wire byte moves LSB first.
// - Bank code, start address, then data bytes.
// - Codes 02h-06h write; others ignore rest.
// - Codes 82h-86h read; others ignore rest.
// - Chip select low frames one transaction.
// - Input sampled on rising serial clock.
// - Data goes to start address, then increments.
// - Only complete bytes are committed.
// - Write shifts out old register contents.
// - Read stores nothing, shifts out contents.
// - Frame-timed registers apply at reflection point.
// - Immediate registers apply on write.
// - Two-wire bytes MSB first, direction last; this port only detects the start condition.
// - Direction zero writes, one reads; no two-wire byte is decoded here.
`timescale 1ns/100ps

module ssrp_serial_port (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic sclk_i,
	input wire logic sdi_i,
	input wire logic chip_sel_n_i,
	input wire logic frame_reflect_i,
	input wire logic [10:0] cfg_index_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_o,
	output logic [1:0] iface_sel_o,
	output logic [7:0] cfg_data_o
);

	// ------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------
	logic [1:0] sclk_sync_reg;
	logic [1:0] sdi_sync_reg;
	logic [1:0] cs_sync_reg;
	logic sclk_prev_reg;
	logic sdi_prev_reg;
	logic cs_prev_reg;

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			sclk_sync_reg <= 2'h0;
			sdi_sync_reg <= 2'h0;
			cs_sync_reg <= 2'h3;
			sclk_prev_reg <= 1'b0;
			sdi_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b1;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
			sdi_sync_reg <= {sdi_sync_reg[0], sdi_i};
			cs_sync_reg <= {cs_sync_reg[0], chip_sel_n_i};
			sclk_prev_reg <= sclk_sync_reg[1];
			sdi_prev_reg <= sdi_sync_reg[1];
			cs_prev_reg <= cs_sync_reg[1];
		end
	end

	wire logic sclk_s = sclk_sync_reg[1];
	wire logic sdi_s = sdi_sync_reg[1];
	wire logic cs_n_s = cs_sync_reg[1];
	wire logic sclk_rise = sclk_s & ~sclk_prev_reg;
	wire logic sclk_fall = ~sclk_s & sclk_prev_reg;
	wire logic cs_fall = ~cs_n_s & cs_prev_reg;
	// A start condition: data falls while the clock is high and select idles high.
	// Limitation: the two-wire byte engine, MSB first with the direction bit last,
	// sits outside this port; here the start condition only claims the shared pins.
	wire logic two_wire_start = cs_n_s & cs_prev_reg & sclk_s & sclk_prev_reg &
		~sdi_s & sdi_prev_reg;

	// ------------------------------------------------------------
	// Interface choice
	// ------------------------------------------------------------
	ssrp_pkg::ssrp_iface_t iface_reg;

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			iface_reg <= ssrp_pkg::IF_NONE;
		end else if (iface_reg == ssrp_pkg::IF_NONE) begin
			if (cs_fall) begin
				iface_reg <= ssrp_pkg::IF_FOUR_WIRE;
			end else if (two_wire_start) begin
				iface_reg <= ssrp_pkg::IF_TWO_WIRE;
			end
		end
	end

	// Once the two-wire bus owns the pins, select activity is ignored.
	wire logic cs_active = ~cs_n_s & (iface_reg != ssrp_pkg::IF_TWO_WIRE);

	// ------------------------------------------------------------
	// Byte framing
	// ------------------------------------------------------------
	ssrp_pkg::ssrp_state_t state_reg;
	logic [2:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [2:0] bank_reg;
	logic is_read_reg;
	logic [7:0] addr_reg;
	logic [7:0] out_byte_reg;
	logic sdo_reg;
	logic sdo_oe_reg;

	wire logic framing = cs_active & (state_reg != ssrp_pkg::ST_IDLE);
	wire logic [7:0] shift_next = {sdi_s, shift_reg[7:1]};
	wire logic byte_done = framing & sclk_rise & (bit_cnt_reg == ssrp_pkg::LAST_BIT);
	wire logic write_code = (shift_next >= ssrp_pkg::WRITE_CODE_FIRST) &&
		(shift_next <= ssrp_pkg::WRITE_CODE_LAST);
	wire logic read_code = (shift_next >= ssrp_pkg::READ_CODE_FIRST) &&
		(shift_next <= ssrp_pkg::READ_CODE_LAST);
	wire logic [2:0] code_bank = shift_next[2:0] - ssrp_pkg::BANK_BASE;
	wire logic [7:0] addr_plus = addr_reg + 8'h01;
	wire logic in_data = state_reg == ssrp_pkg::ST_DATA;

	always_ff @(posedge clock_i) begin
		if (!nrst_i || !cs_active) begin
			state_reg <= ssrp_pkg::ST_IDLE;
		end else if (state_reg == ssrp_pkg::ST_IDLE) begin
			state_reg <= ssrp_pkg::ST_CODE;
		end else if (byte_done) begin
			case (state_reg)
				ssrp_pkg::ST_CODE: begin
					state_reg <= (write_code || read_code) ? ssrp_pkg::ST_ADDR :
						ssrp_pkg::ST_IGNORE;
				end
				ssrp_pkg::ST_ADDR: begin
					state_reg <= ssrp_pkg::ST_DATA;
				end
				ssrp_pkg::ST_DATA: begin
					state_reg <= ssrp_pkg::ST_DATA;
				end
				ssrp_pkg::ST_IGNORE: begin
					state_reg <= ssrp_pkg::ST_IGNORE;
				end
				default: begin
					state_reg <= ssrp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i || !framing) begin
			bit_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
		end else if (sclk_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shift_reg <= shift_next;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			bank_reg <= 3'h0;
			is_read_reg <= 1'b0;
		end else if (byte_done && state_reg == ssrp_pkg::ST_CODE) begin
			bank_reg <= code_bank;
			is_read_reg <= shift_next[ssrp_pkg::READ_FLAG_BIT];
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			addr_reg <= 8'h00;
		end else if (byte_done && state_reg == ssrp_pkg::ST_ADDR) begin
			addr_reg <= shift_next;
		end else if (byte_done && in_data) begin
			addr_reg <= addr_plus;
		end
	end

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	// Shadow holds what the link wrote; active is what the sensor uses.
	// Both are flops, which costs area but lets a frame copy happen in one cycle.
	logic [7:0] shadow_reg [0:ssrp_pkg::REG_COUNT-1];
	logic [7:0] active_reg [0:ssrp_pkg::REG_COUNT-1];

	wire logic mem_we = byte_done & in_data & ~is_read_reg;
	wire logic [10:0] mem_idx = ssrp_pkg::reg_index(bank_reg, addr_reg);
	wire logic [10:0] look_idx = (state_reg == ssrp_pkg::ST_ADDR) ?
		ssrp_pkg::reg_index(bank_reg, shift_next) : ssrp_pkg::reg_index(bank_reg, addr_plus);
	wire logic [7:0] look_data = shadow_reg[look_idx];
	wire logic cfg_in_range = cfg_index_i < 11'(ssrp_pkg::REG_COUNT);

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < ssrp_pkg::REG_COUNT; i++) begin
				shadow_reg[i] <= ssrp_pkg::REG_RESET;
				active_reg[i] <= ssrp_pkg::REG_RESET;
			end
		end else begin
			if (frame_reflect_i) begin
				for (int i = 0; i < ssrp_pkg::REG_COUNT; i++) begin
					if (!ssrp_pkg::is_immediate(11'(i))) begin
						active_reg[i] <= shadow_reg[i];
					end
				end
			end
			if (mem_we) begin
				shadow_reg[mem_idx] <= shift_next;
				if (ssrp_pkg::is_immediate(mem_idx)) begin
					active_reg[mem_idx] <= shift_next;
				end
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			cfg_data_o <= 8'h00;
		end else begin
			cfg_data_o <= cfg_in_range ? active_reg[cfg_index_i] : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Serial output
	// ------------------------------------------------------------
	// The byte is fetched before any write lands, so writes echo old contents.
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			out_byte_reg <= 8'h00;
		end else if (byte_done && (state_reg == ssrp_pkg::ST_ADDR || in_data)) begin
			out_byte_reg <= look_data;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i || !framing) begin
			sdo_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
		end else begin
			sdo_oe_reg <= in_data;
			if (sclk_fall) begin
				sdo_reg <= in_data ? out_byte_reg[bit_cnt_reg] : 1'b0;
			end
		end
	end

	assign serial_data_out_o = sdo_reg;
	assign serial_data_out_oe_o = sdo_oe_reg;
	assign iface_sel_o = iface_reg;

endmodule

// ===== verification/ssrp_serial_port_assertions.sv
// Port checker for the sensor serial register port.
`timescale 1ns/100ps
module ssrp_serial_port_assertions (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic sclk_i,
	input wire logic chip_sel_n_i,
	input wire logic serial_data_out_o,
	input wire logic serial_data_out_oe_o,
	input wire logic [1:0] iface_sel_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	sequence sclk_high_s;
		sclk_i [*3];
	endsequence
	sequence driving_s;
		serial_data_out_oe_o && $past(serial_data_out_oe_o);
	endsequence
	iface_hold_a: assert property (iface_sel_o != 2'h0 |=> $stable(iface_sel_o))
		else $error("interface choice changed");
	two_wire_quiet_a: assert property (
		iface_sel_o == ssrp_pkg::IF_TWO_WIRE |-> !serial_data_out_oe_o)
		else $error("output driven after two-wire lock");
	four_only_a: assert property (
		serial_data_out_oe_o |-> iface_sel_o == ssrp_pkg::IF_FOUR_WIRE)
		else $error("output driven without four-wire choice");
	open_quiet_a: assert property ($fell(chip_sel_n_i) |-> !serial_data_out_oe_o [*8])
		else $error("output driven during code byte");
	idle_off_a: assert property (chip_sel_n_i [*6] |-> !serial_data_out_oe_o)
		else $error("output driven while deselected");
	sdo_off_a: assert property (
		!serial_data_out_oe_o && !$past(serial_data_out_oe_o) |-> !serial_data_out_o)
		else $error("data out not low while idle");
	sdo_fall_a: assert property (
		driving_s ##0 $changed(serial_data_out_o) |-> $past(sclk_i, 6) && !$past(sclk_i, 2))
		else $error("data out changed away from a falling clock");
	sdo_hold_a: assert property (sclk_high_s ##0 driving_s |-> $stable(serial_data_out_o))
		else $error("data out moved while clock high");
endmodule

// ===== verification/ssrp_host_model.sv
// Behavioural host controller driving the four-wire link.
`timescale 1ns/100ps
module ssrp_host_model (
	output logic sclk_o,
	output logic sdi_o,
	output logic chip_sel_n_o,
	input wire logic sdo_i
);
	logic [7:0] rx [0:3];
	initial begin
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		chip_sel_n_o = 1'b1;
	end
	// Extra tail bits make a partial byte; the clock stands low outside frames.
	task automatic xfer(input logic [7:0] tx [0:3], input int count, input int tail);
		logic [7:0] b;
		b = 8'h00;
		rx = '{default: 8'h00};
		chip_sel_n_o = 1'b0;
		#200;
		for (int j = 0; j < count; j++) begin
			for (int i = 0; i < 8; i++) begin
				sdi_o = tx[j][i];
				#200 sclk_o = 1'b1;
				b[i] = sdo_i;
				#200 sclk_o = 1'b0;
			end
			rx[j] = b;
		end
		repeat (tail) begin
			sdi_o = ~sdi_o;
			#200 sclk_o = 1'b1;
			#200 sclk_o = 1'b0;
		end
		#200 chip_sel_n_o = 1'b1;
		sdi_o = ~sdi_o;
		#400;
	endtask
	task automatic start_two_wire();
		sdi_o = 1'b1;
		#200 sclk_o = 1'b1;
		#200 sdi_o = 1'b0;
		#200 sclk_o = 1'b0;
		#400;
	endtask
endmodule

// ===== verification/ssrp_serial_port_tb.sv
// Self-checking bench for the sensor serial register port.
`timescale 1ns/100ps
module ssrp_serial_port_tb;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic frame_reflect_i = 1'b0;
	logic [10:0] cfg_index_i = 11'h000;
	wire sclk, sdi, csn, serial_data_out, sdo_oe;
	wire sdo_line;
	wire [1:0] iface;
	wire [7:0] cfg_data;
	int fail_count = 0;
	int checks_done = 0;
	always #25 clock_i = ~clock_i;
	// With no pull on the line, a released data out reads back inverted, so a
	// read that should be ignored shows all ones unless the port drives it.
	assign sdo_line = sdo_oe ? serial_data_out : ~serial_data_out;
	ssrp_host_model i_ssrp_host_model (.sclk_o(sclk), .sdi_o(sdi), .chip_sel_n_o(csn),
		.sdo_i(sdo_line));
	ssrp_serial_port i_ssrp_serial_port (.clock_i(clock_i), .nrst_i(nrst_i), .sclk_i(sclk),
		.sdi_i(sdi), .chip_sel_n_i(csn), .frame_reflect_i(frame_reflect_i),
		.cfg_index_i(cfg_index_i), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(sdo_oe),
		.iface_sel_o(iface), .cfg_data_o(cfg_data));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic rst();
		nrst_i = 1'b0;
		repeat (3) @(negedge clock_i);
		nrst_i = 1'b1;
		repeat (4) @(negedge clock_i);
	endtask
	task automatic peek(input logic [10:0] idx, input logic [7:0] exp);
		cfg_index_i = idx;
		repeat (2) @(negedge clock_i);
		check(cfg_data, exp);
	endtask
	task automatic frame();
		@(negedge clock_i) frame_reflect_i = 1'b1;
		@(negedge clock_i) frame_reflect_i = 1'b0;
		repeat (2) @(negedge clock_i);
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_i) i_ssrp_host_model.xfer('{c, a, d, 8'h00}, 3, 0);
	endtask
	// One dummy byte per register read; its echo lands in the third received byte.
	task automatic rd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] exp);
		@(negedge clock_i) i_ssrp_host_model.xfer('{c, a, 8'hFF, 8'h00}, 3, 0);
		check(i_ssrp_host_model.rx[2], exp);
	endtask
	// The scenarios need about a fifth of this span; the rest is margin.
	initial begin
		#1000000;
		fail_count++;
		wrap_up();
	end
	initial begin
		rst();
		@(negedge clock_i) i_ssrp_host_model.xfer('{8'h02, 8'h10, 8'hA5, 8'h5A}, 4, 4);
		check(i_ssrp_host_model.rx[2], 8'h00);
		check(i_ssrp_host_model.rx[3], 8'h00);
		check({6'h00, iface}, {6'h00, ssrp_pkg::IF_FOUR_WIRE});
		peek(11'h010, 8'h00);
		frame();
		peek(11'h010, 8'hA5);
		peek(11'h011, 8'h5A);
		peek(11'h012, 8'h00);
		rd(8'h82, 8'h11, 8'h5A);
		rd(8'h82, 8'h11, 8'h5A);
		wr(8'h02, 8'h00, 8'h3C);
		peek(11'h000, 8'h3C);
		wr(8'h02, 8'h10, 8'hC3);
		check(i_ssrp_host_model.rx[2], 8'hA5);
		for (logic [7:0] k = 8'h00; k < 8'h05; k++) begin
			wr(8'h02 + k, 8'h40, 8'h10 + k);
			rd(8'h82 + k, 8'h40, 8'h10 + k);
		end
		frame();
		for (logic [7:0] k = 8'h00; k < 8'h05; k++) peek({k[2:0], 8'h40}, 8'h10 + k);
		wr(8'h07, 8'h40, 8'h77);
		rd(8'h87, 8'h40, 8'hFF);
		rd(8'h82, 8'h40, 8'h10);
		rst();
		i_ssrp_host_model.start_two_wire();
		check({6'h00, iface}, {6'h00, ssrp_pkg::IF_TWO_WIRE});
		wr(8'h02, 8'h00, 8'h3C);
		check(i_ssrp_host_model.rx[2], 8'hFF);
		peek(11'h000, 8'h00);
		check({6'h00, iface}, {6'h00, ssrp_pkg::IF_TWO_WIRE});
		wrap_up();
	end
endmodule
bind ssrp_serial_port ssrp_serial_port_assertions i_ssrp_serial_port_assertions (
	.clock_i(clock_i), .nrst_i(nrst_i), .sclk_i(sclk_i), .chip_sel_n_i(chip_sel_n_i),
	.serial_data_out_o(serial_data_out_o), .serial_data_out_oe_o(serial_data_out_oe_o),
	.iface_sel_o(iface_sel_o));
